// >>> src/tslm_pkg.sv
// transmit loss-of-signal monitor: register map, field layout, reset values
// assumes one recovered data bit per mclk cycle and an 8-bit register port
package tslm_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_LOSS_CTRL     = 8'h8A;
    localparam logic [7:0] OFS_LOSS_STATUS   = 8'h8B;
    localparam logic [7:0] OFS_RL_ASSERT     = 8'h91;
    localparam logic [7:0] OFS_RL_CLEAR      = 8'h92;
    localparam logic [7:0] OFS_PHASE_OFFSET  = 8'h98;
    localparam logic [7:0] OFS_EYE_MEASURE   = 8'h99;
    localparam logic [7:0] OFS_EYE_CONFIG    = 8'h9A;
    localparam logic [7:0] OFS_EYE_RELEASE   = 8'h9B;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_LOSS_CTRL     = 8'h0E;
    localparam logic [7:0] RST_RL_ASSERT     = 8'h00;
    localparam logic [7:0] RST_RL_CLEAR      = 8'h60;
    localparam logic [6:0] RST_PHASE_OFFSET  = 7'h00;
    localparam logic [7:0] RST_EYE_CONFIG    = 8'h05;
    localparam logic [5:0] RST_EYE_RELEASE   = 6'h08;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int STS_QUALITY   = 4;
    localparam int STS_LAST_LVL  = 3;
    localparam int STS_RL_LOSS   = 2;
    localparam int STS_LOSS      = 0;
    localparam int CTL_QUAL_EN   = 3;
    localparam int CTL_SEL_HI    = 2;
    localparam int CTL_SEL_LO    = 1;
    localparam int CFG_THR_HI    = 7;
    localparam int CFG_THR_LO    = 2;

    // ----------------------------------------------------------------
    // detect select codes and run-length arithmetic
    // ----------------------------------------------------------------
    localparam logic [1:0] SEL_OFF   = 2'h0;
    localparam logic [1:0] SEL_ZEROS = 2'h1;
    localparam int ASSERT_MUL  = 5;
    localparam int ASSERT_ADD  = 2;
    localparam int BLOCK_BITS  = 1024;
    localparam int CLEAR_MUL   = 16;
    localparam int CLEAR_ADD   = 1;

    // run-length detector states
    typedef enum logic [1:0] {
        RL_SEARCH = 2'h1,
        RL_LOST   = 2'h2
    } tslm_rl_state_t;
endpackage

// >>> src/tslm_runlen_if.sv
// carries run-length configuration and status between top and detector
// assumes both ends sit on mclk
`timescale 1ns/1ps
interface tslm_runlen_if;
    logic [1:0] detectSelect;
    logic [7:0] assertLimit;
    logic [7:0] clearLimit;
    logic       runlengthLoss;
    logic       lastTriggerLevel;

    modport ctrl (output detectSelect, output assertLimit, output clearLimit,
                  input runlengthLoss, input lastTriggerLevel);
    modport det  (input detectSelect, input assertLimit, input clearLimit,
                  output runlengthLoss, output lastTriggerLevel);
endinterface

// >>> src/tslm_runlength.sv
// run-length loss detector on the synchronised serial bit stream
// assumes one data bit per mclk, already synchronised by the caller
`timescale 1ns/1ps
module tslm_runlength #(
    parameter int RUN_W = 21,
    parameter int GOOD_W = 12
) (
    // clock and reset
    input  wire logic   mclk,
    input  wire logic   rst_n,
    // data
    input  wire logic   dataBit,
    // configuration and status
    tslm_runlen_if.det  rl
);
    // refuse counters too narrow for the largest 8-bit limits
    if (RUN_W < 21 || GOOD_W < 12)
    begin : gBadWidth
        $error("tslm_runlength: counters too narrow for 8-bit limits");
    end

    tslm_pkg::tslm_rl_state_t state, next_state;
    logic [RUN_W-1:0]  runCnt, next_runCnt;
    logic [9:0]        bitCnt, next_bitCnt;
    logic              seenEdge, next_seenEdge;
    logic [GOOD_W-1:0] goodCnt, next_goodCnt;
    logic              prevBit, next_prevBit;
    logic              lastLvl, next_lastLvl;
    logic [RUN_W-1:0]  assertTarget;
    logic [GOOD_W-1:0] clearTarget;
    logic              edgeNow;
    logic              qualifies;

    // ----------------------------------------------------------------
    // thresholds from the limit registers
    // ----------------------------------------------------------------
    assign assertTarget = RUN_W'((RUN_W'(rl.assertLimit) * RUN_W'(tslm_pkg::ASSERT_MUL)
                        + RUN_W'(tslm_pkg::ASSERT_ADD)) * RUN_W'(tslm_pkg::BLOCK_BITS));
    assign clearTarget  = GOOD_W'(GOOD_W'(rl.clearLimit) * GOOD_W'(tslm_pkg::CLEAR_MUL)
                        + GOOD_W'(tslm_pkg::CLEAR_ADD));
    assign edgeNow      = dataBit != prevBit;
    assign qualifies    = (rl.detectSelect != tslm_pkg::SEL_ZEROS) || !dataBit;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state    = state;
        next_prevBit  = dataBit;
        next_lastLvl  = lastLvl;
        next_runCnt   = edgeNow ? RUN_W'(1) : runCnt + RUN_W'(~&runCnt);
        next_bitCnt   = bitCnt;
        next_seenEdge = seenEdge;
        next_goodCnt  = goodCnt;
        case (state)
            tslm_pkg::RL_SEARCH:
            begin
                next_bitCnt   = '0;
                next_seenEdge = 1'b0;
                next_goodCnt  = '0;
                if (rl.detectSelect != tslm_pkg::SEL_OFF && qualifies
                    && next_runCnt >= assertTarget)
                begin
                    next_state   = tslm_pkg::RL_LOST;
                    next_lastLvl = dataBit;
                end
            end
            tslm_pkg::RL_LOST:
            begin
                next_bitCnt   = bitCnt + 10'h001;
                next_seenEdge = seenEdge | edgeNow;
                if (&bitCnt)
                begin
                    next_seenEdge = 1'b0;
                    if (seenEdge | edgeNow)
                        next_goodCnt = goodCnt + GOOD_W'(1);
                    else
                        next_goodCnt = '0;
                    if ((seenEdge | edgeNow) && (goodCnt + GOOD_W'(1) >= clearTarget))
                        next_state = tslm_pkg::RL_SEARCH;
                end
                if (rl.detectSelect == tslm_pkg::SEL_OFF)
                    next_state = tslm_pkg::RL_SEARCH;
            end
            default:
                next_state = tslm_pkg::RL_SEARCH;
        endcase
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state    <= tslm_pkg::RL_SEARCH;
            prevBit  <= 1'b0;
            lastLvl  <= 1'b0;
            runCnt   <= '0;
            bitCnt   <= '0;
            seenEdge <= 1'b0;
            goodCnt  <= '0;
        end
        else
        begin
            state    <= next_state;
            prevBit  <= next_prevBit;
            lastLvl  <= next_lastLvl;
            runCnt   <= next_runCnt;
            bitCnt   <= next_bitCnt;
            seenEdge <= next_seenEdge;
            goodCnt  <= next_goodCnt;
        end
    end

    assign rl.runlengthLoss    = state == tslm_pkg::RL_LOST;
    assign rl.lastTriggerLevel = lastLvl;
endmodule // tslm_runlength

// >>> src/tslm_regs.sv
// transmit loss-of-signal monitor registers with quality and run-length logic
// assumes an 8-bit register port from the serial control slave, on mclk
`timescale 1ns/1ps
module tslm_regs (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic      [7:0]  regRdData,
    // monitored inputs, asynchronous to mclk
    input  wire logic        serialBit,
    input  wire logic        lockLostFlag,
    input  wire logic [5:0]  eyeWidthIn,
    // outputs to the datapath
    output logic      [6:0]  samplePhaseOffset,
    output logic             signalLossFlag,
    output logic             qualityAlarmFlag
);
    tslm_runlen_if rlIf ();

    logic [1:0] bitSync;
    logic [1:0] lockSync;
    logic [5:0] eyeSync0, eyeSync1;
    logic [5:0] eyeSync2;
    logic [5:0] eyeVal, next_eyeVal;
    logic [7:0] lossCtrl, next_lossCtrl;
    logic [7:0] rlAssert, next_rlAssert;
    logic [7:0] rlClear, next_rlClear;
    logic [6:0] phaseOfs, next_phaseOfs;
    logic [7:0] eyeCfg, next_eyeCfg;
    logic [5:0] eyeRel, next_eyeRel;
    logic       qual, next_qual;
    logic       loss, next_loss;
    logic [7:0] rdData, next_rdData;
    logic [7:0] statusWord;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bitSync  <= 2'h0;
            lockSync <= 2'h0;
            eyeSync0 <= 6'h00;
            eyeSync1 <= 6'h00;
            eyeSync2 <= 6'h00;
            eyeVal   <= 6'h00;
        end
        else
        begin
            bitSync  <= {bitSync[0], serialBit};
            lockSync <= {lockSync[0], lockLostFlag};
            eyeSync0 <= eyeWidthIn;
            eyeSync1 <= eyeSync0;
            eyeSync2 <= eyeSync1;
            eyeVal   <= next_eyeVal;
        end
    end

    // eye word taken only after two equal synced samples, so bits
    // that cross on different edges never form a false value
    assign next_eyeVal = (eyeSync1 == eyeSync2) ? eyeSync1 : eyeVal;

    // ----------------------------------------------------------------
    // run-length detector
    // ----------------------------------------------------------------
    assign rlIf.detectSelect = lossCtrl[tslm_pkg::CTL_SEL_HI:tslm_pkg::CTL_SEL_LO];
    assign rlIf.assertLimit  = rlAssert;
    assign rlIf.clearLimit   = rlClear;

    tslm_runlength #(
        .RUN_W  (21),
        .GOOD_W (12)
    ) uRunlength (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .dataBit (bitSync[1]),
        .rl      (rlIf)
    );

    // ----------------------------------------------------------------
    // quality alarm with hysteresis and overall loss
    // ----------------------------------------------------------------
    always_comb
    begin
        next_qual = qual;
        if (lockSync[1])
            next_qual = 1'b0;
        else if (eyeVal < eyeCfg[tslm_pkg::CFG_THR_HI:tslm_pkg::CFG_THR_LO])
            next_qual = 1'b1;
        else if (eyeVal >= eyeRel)
            next_qual = 1'b0;
        next_loss = rlIf.runlengthLoss
                  | (lossCtrl[tslm_pkg::CTL_QUAL_EN] & next_qual);
    end

    // ----------------------------------------------------------------
    // register writes and read mux
    // ----------------------------------------------------------------
    // status word: flags at their field positions, reserved bits zero
    always_comb
    begin
        statusWord                        = 8'h00;
        statusWord[tslm_pkg::STS_QUALITY]  = qual;
        statusWord[tslm_pkg::STS_LAST_LVL] = rlIf.lastTriggerLevel;
        statusWord[tslm_pkg::STS_RL_LOSS]  = rlIf.runlengthLoss;
        statusWord[tslm_pkg::STS_LOSS]     = loss;
    end

    always_comb
    begin
        next_lossCtrl = lossCtrl;
        next_rlAssert = rlAssert;
        next_rlClear  = rlClear;
        next_phaseOfs = phaseOfs;
        next_eyeCfg   = eyeCfg;
        next_eyeRel   = eyeRel;
        next_rdData   = rdData;
        if (regWrEn)
        begin
            case (regAddr)
                tslm_pkg::OFS_LOSS_CTRL:    next_lossCtrl = {4'h0, regWrData[3:1], 1'b0};
                tslm_pkg::OFS_RL_ASSERT:    next_rlAssert = regWrData;
                tslm_pkg::OFS_RL_CLEAR:     next_rlClear  = regWrData;
                tslm_pkg::OFS_PHASE_OFFSET: next_phaseOfs = regWrData[6:0];
                tslm_pkg::OFS_EYE_CONFIG:   next_eyeCfg   = regWrData;
                tslm_pkg::OFS_EYE_RELEASE:  next_eyeRel   = regWrData[5:0];
                default:                    next_rdData   = rdData;
            endcase
        end
        if (regRdEn)
        begin
            case (regAddr)
                tslm_pkg::OFS_LOSS_CTRL:    next_rdData = lossCtrl;
                tslm_pkg::OFS_LOSS_STATUS:  next_rdData = statusWord;
                tslm_pkg::OFS_RL_ASSERT:    next_rdData = rlAssert;
                tslm_pkg::OFS_RL_CLEAR:     next_rdData = rlClear;
                tslm_pkg::OFS_PHASE_OFFSET: next_rdData = {1'b0, phaseOfs};
                tslm_pkg::OFS_EYE_MEASURE:  next_rdData = {2'h0, eyeVal};
                tslm_pkg::OFS_EYE_CONFIG:   next_rdData = eyeCfg;
                tslm_pkg::OFS_EYE_RELEASE:  next_rdData = {2'h0, eyeRel};
                default:                    next_rdData = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lossCtrl <= tslm_pkg::RST_LOSS_CTRL;
            rlAssert <= tslm_pkg::RST_RL_ASSERT;
            rlClear  <= tslm_pkg::RST_RL_CLEAR;
            phaseOfs <= tslm_pkg::RST_PHASE_OFFSET;
            eyeCfg   <= tslm_pkg::RST_EYE_CONFIG;
            eyeRel   <= tslm_pkg::RST_EYE_RELEASE;
            qual     <= 1'b0;
            loss     <= 1'b0;
            rdData   <= 8'h00;
        end
        else
        begin
            lossCtrl <= next_lossCtrl;
            rlAssert <= next_rlAssert;
            rlClear  <= next_rlClear;
            phaseOfs <= next_phaseOfs;
            eyeCfg   <= next_eyeCfg;
            eyeRel   <= next_eyeRel;
            qual     <= next_qual;
            loss     <= next_loss;
            rdData   <= next_rdData;
        end
    end

    assign regRdData         = rdData;
    assign samplePhaseOffset = phaseOfs;
    assign signalLossFlag    = loss;
    assign qualityAlarmFlag  = qual;
endmodule // tslm_regs

// >>> verif/tslm_properties.sv
// checker: port-level assertions for the loss monitor registers
// assumes binding into tslm_regs, single mclk domain
`timescale 1ns/1ps
module tslm_properties (
    // clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    // monitored inputs and outputs
    input wire logic       serialBit,
    input wire logic       lockLostFlag,
    input wire logic [5:0] eyeWidthIn,
    input wire logic [6:0] samplePhaseOffset,
    input wire logic       signalLossFlag,
    input wire logic       qualityAlarmFlag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [11:0] runCount;
    logic [11:0] next_runCount;
    logic        lastBit;
    // ----------------------------------------
    // run length seen at the serial pin
    // ----------------------------------------
    always_comb
    begin
        next_runCount = (runCount == 12'hFFF) ? runCount : runCount + 12'h001;
        if (serialBit != lastBit)
            next_runCount = 12'h001;
    end
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            runCount <= 12'h000;
            lastBit  <= 1'b0;
        end
        else
        begin
            runCount <= next_runCount;
            lastBit  <= serialBit;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    lock_forces_a: assert property (lockLostFlag [*5] |-> !qualityAlarmFlag)
        else $error("quality alarm high under lock loss");
    eye_full_a: assert property ((eyeWidthIn == 6'h3F && !lockLostFlag) [*7]
        |-> !qualityAlarmFlag) else $error("quality alarm high at full eye");
    status_res_a: assert property (regRdEn && regAddr == 8'h8B
        |=> regRdData[7:5] == 3'h0 && !regRdData[1]) else $error("status reserved set");
    status_flags_a: assert property (regRdEn && regAddr == 8'h8B |=>
        regRdData[0] == $past(signalLossFlag) && regRdData[4] == $past(qualityAlarmFlag))
        else $error("status flags differ from pins");
    eye_res_a: assert property (regRdEn && regAddr == 8'h99 |=> regRdData[7:6] == 2'h0)
        else $error("eye reserved set");
    phase_read_a: assert property (regRdEn && regAddr == 8'h98 && !regWrEn
        |=> regRdData == {1'b0, samplePhaseOffset}) else $error("phase readback");
    release_res_a: assert property (regRdEn && regAddr == 8'h9B |=> regRdData[7:6] == 2'h0)
        else $error("release reserved set");
    runlen_min_a: assert property ($rose(signalLossFlag) && !qualityAlarmFlag
        |-> $past(runCount, 3) >= 12'h7F8) else $error("run-length loss too early");
    // main scenarios
    loss_rise_c: cover property ($rose(signalLossFlag));
    qual_rise_c: cover property ($rose(qualityAlarmFlag));
    lock_qual_c: cover property (lockLostFlag && $fell(qualityAlarmFlag));
endmodule // tslm_properties

bind tslm_regs tslm_properties u_props (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .serialBit(serialBit), .lockLostFlag(lockLostFlag), .eyeWidthIn(eyeWidthIn),
    .samplePhaseOffset(samplePhaseOffset), .signalLossFlag(signalLossFlag),
    .qualityAlarmFlag(qualityAlarmFlag));

// >>> verif/tslm_host.sv
// host model: serial-port master reduced to the register strobes
// assumes the block takes strobes on rising mclk; drives on falling
`timescale 1ns/1ps
module tslm_host (
    // clock
    input wire logic       mclk,
    // register port
    output logic     [7:0] regAddr,
    output logic     [7:0] regWrData,
    output logic           regWrEn,
    output logic           regRdEn,
    input wire logic [7:0] regRdData
);
    initial
    begin
        regAddr   = 8'h00;
        regWrData = 8'h00;
        regWrEn   = 1'b0;
        regRdEn   = 1'b0;
    end
    // one write, strobe over one rising edge, then lines scrambled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        regAddr   = a;
        regWrData = (a == tslm_pkg::OFS_EYE_CONFIG) ? {d[7:2], 2'h1} : d;
        regWrEn   = 1'b1;
        @(negedge mclk);
        regWrEn   = 1'b0;
        regAddr   = ~a;
        regWrData = ~d;
    endtask
    // one read, data taken the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge mclk);
        regRdEn = 1'b0;
        regAddr = ~a;
        d       = regRdData;
    endtask
endmodule // tslm_host

// >>> verif/tx_signal_loss_monitor_regs_bench.sv
// bench: register sequences with expected values for the loss monitor
// assumes tslm_regs, host model tslm_host and the bound checker
`timescale 1ns/1ps
module tx_signal_loss_monitor_regs_bench;
    logic mclk, rst_n, regWrEn, regRdEn, serialBit, lockLostFlag;
    logic signalLossFlag, qualityAlarmFlag, toggleOn, level;
    logic [7:0] regAddr, regWrData, regRdData, v;
    logic [5:0] eyeWidthIn;
    logic [6:0] samplePhaseOffset;
    int   miscompares, total_checks;
    logic [7:0] ra [9] = '{8'h8A, 8'h8B, 8'h91, 8'h92, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'h90};
    logic [7:0] re [9] = '{8'h0E, 8'h00, 8'h00, 8'h60, 8'h00, 8'h3F, 8'h05, 8'h08, 8'h00};
    tslm_host host (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));
    tslm_regs dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .serialBit(serialBit),
        .lockLostFlag(lockLostFlag), .eyeWidthIn(eyeWidthIn),
        .samplePhaseOffset(samplePhaseOffset), .signalLossFlag(signalLossFlag),
        .qualityAlarmFlag(qualityAlarmFlag));
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // serial stream: toggling or a held level
    initial
    begin
        serialBit = 1'b0;
        forever @(negedge mclk) serialBit <= toggleOn ? ~serialBit : level;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
        host.rd(a, v);
        chk(n, e, v);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // bounded wait for the loss output to reach a level
    task automatic waitLoss(input logic e, input int m);
        int i;
        i = 0;
        while (signalLossFlag !== e && i < m)
        begin
            @(negedge mclk);
            i++;
        end
        chk("loss flag", {7'h0, e}, {7'h0, signalLossFlag});
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (40000) @(posedge mclk);
        miscompares++;
        report_and_stop();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rst_n = 1'b0;
        toggleOn = 1'b1;
        level = 1'b0;
        lockLostFlag = 1'b0;
        eyeWidthIn = 6'h3F;
        miscompares = 0;
        total_checks = 0;
        idle(12);
        rst_n = 1'b1;
        idle(8);
        for (int i = 0; i < 9; i++)
            rdc(ra[i], re[i], "reset value");
        host.wr(8'h98, 8'h41);
        rdc(8'h98, 8'h41, "phase");
        chk("phase pins", 8'h41, {1'b0, samplePhaseOffset});
        host.wr(8'h98, 8'hBF);
        rdc(8'h98, 8'h3F, "phase");
        host.wr(8'h9B, 8'hFF);
        rdc(8'h9B, 8'h3F, "release");
        host.wr(8'h9B, 8'h08);
        host.wr(8'h8A, 8'hFF);
        rdc(8'h8A, 8'h0E, "ctrl");
        host.wr(8'h8B, 8'hFF);
        rdc(8'h8B, 8'h00, "status");
        host.wr(8'h99, 8'h00);
        rdc(8'h99, 8'h3F, "eye");
        host.wr(8'h91, 8'hAA);
        rdc(8'h91, 8'hAA, "assert limit");
        host.wr(8'h92, 8'h55);
        rdc(8'h92, 8'h55, "clear limit");
        host.wr(8'h91, 8'h00);
        host.wr(8'h92, 8'h00);
        // quality alarm thresholds and hysteresis
        eyeWidthIn = 6'h00;
        idle(6);
        chk("quality", 8'h01, {7'h0, qualityAlarmFlag});
        rdc(8'h8B, 8'h11, "status");
        eyeWidthIn = 6'h05;
        idle(6);
        chk("quality", 8'h01, {7'h0, qualityAlarmFlag});
        eyeWidthIn = 6'h08;
        idle(6);
        chk("quality", 8'h00, {7'h0, qualityAlarmFlag});
        host.wr(8'h9A, 8'h29);
        idle(3);
        chk("quality", 8'h01, {7'h0, qualityAlarmFlag});
        lockLostFlag = 1'b1;
        idle(6);
        chk("quality", 8'h00, {7'h0, qualityAlarmFlag});
        lockLostFlag = 1'b0;
        idle(6);
        chk("quality", 8'h01, {7'h0, qualityAlarmFlag});
        host.wr(8'h8A, 8'h06);
        idle(3);
        chk("loss off", 8'h00, {7'h0, signalLossFlag});
        eyeWidthIn = 6'h3F;
        // run-length detection, zeros only then both levels
        host.wr(8'h8A, 8'h02);
        toggleOn <= 1'b0;
        level <= 1'b1;
        idle(2100);
        chk("ones ignored", 8'h00, {7'h0, signalLossFlag});
        level <= 1'b0;
        idle(2040);
        chk("early loss", 8'h00, {7'h0, signalLossFlag});
        waitLoss(1'b1, 30);
        rdc(8'h8B, 8'h05, "status");
        idle(1500);
        chk("loss held", 8'h01, {7'h0, signalLossFlag});
        toggleOn <= 1'b1;
        waitLoss(1'b0, 2100);
        host.wr(8'h8A, 8'h04);
        toggleOn <= 1'b0;
        level <= 1'b1;
        idle(2040);
        chk("early loss", 8'h00, {7'h0, signalLossFlag});
        waitLoss(1'b1, 30);
        rdc(8'h8B, 8'h0D, "status");
        host.wr(8'h8A, 8'h00);
        waitLoss(1'b0, 3);
        toggleOn <= 1'b1;
        idle(4);
        report_and_stop();
    end
endmodule // tx_signal_loss_monitor_regs_bench
